/* File: rtl/icm_master.sv */
// Purpose: I2C master interrupt sources and start/stop condition logic
// Assumes: open-drain SDA/SCL, output enable pulls the wire low
// Notes: registers reached over AXI4-Lite; bus pins synchronised in two stages
// Notes on behaviour
// RULE_01 - Three interrupt sources exist: transmit, receive, not-acknowledge.
// RULE_02 - Not-acknowledge flag rises on NAK received or sent with start/stop set.
// RULE_03 - NAK sets status bit 0; only setting start or stop clears it.
// RULE_04 - Pending NAK suspends all bus activity until cleared.
// RULE_05 - Software checks the NAK source before any other source.
// RULE_06 - Receive flag rises after a full byte; data register read clears it.
// RULE_07 - Pending receive flag stalls all further bus action.
// RULE_08 - Transmit flag only with enable set and data register empty.
// RULE_09 - Idle controller requests transmit when enabled and data empty.
// RULE_10 - Start set with no shift or data content requests transmit.
// RULE_11 - First address bit out with read bit low requests transmit.
// RULE_12 - First bit of a ten-bit address out requests transmit.
// RULE_13 - First bit of each write data byte out requests transmit.
// RULE_14 - Any data register write clears a pending transmit flag.
// RULE_15 - The controller initiates transfers and drives every start and stop.
// RULE_16 - Start: SDA falls while SCL is high.
// RULE_17 - Stop: SDA rises in the middle of SCL high.
// RULE_18 - SDA changes mid SCL low and is sampled mid SCL high.
// RULE_19 - Software sets start or stop to begin or end a transfer.
// RULE_20 - Slave not-acknowledge in the ack slot leads to a stop.
// RULE_21 - Stop is sent when no more data or stop bit is set.
// RULE_22 - Bus halts while a slave holds SCL low.
// RULE_23 - Start and stop bits clear themselves once the condition is made.
//
// The AXI4-Lite register port and the register offsets were left to the implementer.
`timescale 1ns/1ns
`include "icm_params.svh"

module icm_master
  import icm_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // AXI4-Lite write address and data
  input wire logic [3:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read
  input wire logic [3:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // I2C pins, open drain
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe,
  input wire logic scl_i,
  output logic scl_o,
  output logic scl_oe,
  // Interrupt source levels
  output logic tx_irq,
  output logic rx_irq,
  output logic nak_irq
);

  icm_state_s s_r;
  icm_state_s s_nxt;
  logic transmit_irq_enable;
  logic sda_s;
  logic scl_s;
  logic tick;
  logic wr_go;
  logic rd_go;
  logic [31:0] rd_val;
  logic [7:0] stat;

  // Synchronised pins: only the second stage is read
  assign sda_s = s_r.sda_sy[1];
  assign scl_s = s_r.scl_sy[1];

  // Transmit request, combinational over state; enable and empty gate all
  always_comb begin
    transmit_irq_enable = 1'b0;
    if (s_r.phase == ICM_IDLE && !s_r.ctrl[`ICM_CTL_START]) begin
      transmit_irq_enable = 1'b1; // see RULE_09
    end else if (s_r.ctrl[`ICM_CTL_START] && !s_r.shift_full) begin
      transmit_irq_enable = 1'b1; // see RULE_10
    end else if (s_r.phase == ICM_SEND && s_r.bitn != `ICM_BIT_LAST) begin
      // Past the first bit of an address or write byte
      if (s_r.first_addr) begin
        transmit_irq_enable = !s_r.rd || s_r.ctrl[`ICM_CTL_TENBIT]; // see RULE_11 see RULE_12
      end else begin
        transmit_irq_enable = !s_r.rd; // see RULE_13
      end
    end
    transmit_irq_enable = transmit_irq_enable && s_r.ctrl[`ICM_CTL_TXIE] && !s_r.data_full; // see RULE_08
  end

  // Status word
  always_comb begin
    stat = 8'h00;
    stat[`ICM_ST_NAK] = s_r.nak; // see RULE_03
    stat[`ICM_ST_TXI] = transmit_irq_enable;
    stat[`ICM_ST_RXI] = s_r.rxi;
    stat[`ICM_ST_TDRE] = !s_r.data_full;
    stat[`ICM_ST_RD] = s_r.rd;
    stat[`ICM_ST_BUSY] = s_r.phase != ICM_IDLE;
    stat[`ICM_ST_ACK] = s_r.ack;
  end

  // Quarter-bit tick; a slave holding SCL low stretches the high quarters
  assign tick = (s_r.cnt == 8'h00) &&
                !(s_r.qtr[1] && !scl_s); // see RULE_22

  assign wr_go = s_r.aw_ok && s_r.w_ok && !s_r.bvalid;
  assign rd_go = s_axi_arvalid && !s_r.rvalid;

  // Read decode
  always_comb begin
    rd_val = 32'h0000_0000;
    if (s_axi_araddr == `ICM_OFF_DATA) begin
      rd_val = {24'h00_0000, s_r.rxdata};
    end else if (s_axi_araddr == `ICM_OFF_STAT) begin
      rd_val = {24'h00_0000, stat};
    end else if (s_axi_araddr == `ICM_OFF_CTRL) begin
      rd_val = {27'h000_0000, s_r.ctrl};
    end else if (s_axi_araddr == `ICM_OFF_DIV) begin
      rd_val = {24'h00_0000, s_r.div};
    end
  end

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    s_nxt = s_r;
    s_nxt.sda_sy = {s_r.sda_sy[0], sda_i};
    s_nxt.scl_sy = {s_r.scl_sy[0], scl_i};
    s_nxt.cnt = (s_r.cnt == 8'h00) ? (tick ? s_r.div : 8'h00) : s_r.cnt - 8'h01;

    // Bus side; NAK or unread byte freezes the sequencer
    if (tick && !s_r.nak && !s_r.rxi) begin // see RULE_04 see RULE_07
      s_nxt.qtr = s_r.qtr + 2'h1;
      case (s_r.phase)
        ICM_IDLE: begin
          s_nxt.qtr = 2'h0;
          s_nxt.sda_oe = 1'b0;
          s_nxt.scl_oe = 1'b0;
          if (s_r.ctrl[`ICM_CTL_START] && s_r.data_full) begin // see RULE_15
            s_nxt.phase = ICM_START;
            s_nxt.qtr = 2'h2;
          end
        end
        ICM_START: begin
          // Quarter 2: SCL high, pull SDA; quarter 3: drop SCL
          if (s_r.qtr == 2'h2) begin
            s_nxt.sda_oe = 1'b1; // see RULE_16
          end else if (s_r.qtr == 2'h3) begin
            s_nxt.scl_oe = 1'b1;
            s_nxt.shift = s_r.data;
            s_nxt.shift_full = 1'b1;
            s_nxt.data_full = 1'b0;
            s_nxt.rd = s_r.data[0];
            s_nxt.first_addr = 1'b1;
            s_nxt.bitn = `ICM_BIT_LAST;
            s_nxt.ctrl[`ICM_CTL_START] = 1'b0; // see RULE_23
            s_nxt.phase = ICM_SEND;
          end
        end
        ICM_SEND, ICM_PUTACK: begin
          // Drive mid low, release SCL, drop it after the high half
          if (s_r.qtr == 2'h0) begin
            s_nxt.sda_oe = (s_r.phase == ICM_SEND) ? !s_r.shift[7] // see RULE_18
                                                   : !s_r.ctrl[`ICM_CTL_NAK];
          end else if (s_r.qtr == 2'h1) begin
            s_nxt.scl_oe = 1'b0;
          end else if (s_r.qtr == 2'h3) begin
            s_nxt.scl_oe = 1'b1;
            if (s_r.phase == ICM_PUTACK) begin
              s_nxt.phase = ICM_RECV;
              s_nxt.bitn = `ICM_BIT_LAST;
              if (s_r.ctrl[`ICM_CTL_NAK] &&
                  (s_r.ctrl[`ICM_CTL_START] || s_r.ctrl[`ICM_CTL_STOP])) begin
                s_nxt.nak = 1'b1; // see RULE_02
              end
              if (s_r.ctrl[`ICM_CTL_NAK] || s_r.ctrl[`ICM_CTL_STOP]) begin
                s_nxt.phase = ICM_STOP;
              end
            end else begin
              s_nxt.shift = {s_r.shift[6:0], 1'b0};
              s_nxt.bitn = s_r.bitn - 3'h1;
              if (s_r.bitn == 3'h0) begin
                s_nxt.phase = ICM_GETACK;
              end
            end
          end
        end
        ICM_GETACK, ICM_RECV: begin
          if (s_r.qtr == 2'h0) begin
            s_nxt.sda_oe = 1'b0;
          end else if (s_r.qtr == 2'h1) begin
            s_nxt.scl_oe = 1'b0;
          end else if (s_r.qtr == 2'h2) begin
            // Sample mid SCL high
            if (s_r.phase == ICM_GETACK) begin
              s_nxt.ack = !sda_s; // see RULE_18
            end else begin
              s_nxt.shift = {s_r.shift[6:0], sda_s};
            end
          end else begin
            s_nxt.scl_oe = 1'b1;
            if (s_r.phase == ICM_RECV) begin
              s_nxt.bitn = s_r.bitn - 3'h1;
              if (s_r.bitn == 3'h0) begin
                s_nxt.rxdata = s_r.shift;
                s_nxt.rxi = 1'b1; // see RULE_06
                s_nxt.phase = ICM_PUTACK;
              end
            end else if (!s_r.ack) begin
              s_nxt.nak = 1'b1; // see RULE_02
              s_nxt.phase = ICM_STOP; // see RULE_20
            end else if (s_r.rd && !s_r.ctrl[`ICM_CTL_TENBIT]) begin
              s_nxt.first_addr = 1'b0;
              s_nxt.shift_full = 1'b0;
              s_nxt.bitn = `ICM_BIT_LAST;
              s_nxt.phase = ICM_RECV;
            end else if (s_r.ctrl[`ICM_CTL_STOP] || !s_r.data_full) begin
              s_nxt.shift_full = 1'b0;
              s_nxt.phase = ICM_STOP; // see RULE_21
            end else begin
              s_nxt.shift = s_r.data;
              s_nxt.data_full = 1'b0;
              s_nxt.first_addr = 1'b0;
              s_nxt.ctrl[`ICM_CTL_TENBIT] = 1'b0;
              s_nxt.bitn = `ICM_BIT_LAST;
              s_nxt.phase = ICM_SEND;
            end
          end
        end
        ICM_STOP: begin
          // Pull SDA mid low, release SCL, release SDA mid high
          if (s_r.qtr == 2'h0) begin
            s_nxt.sda_oe = 1'b1;
          end else if (s_r.qtr == 2'h1) begin
            s_nxt.scl_oe = 1'b0;
          end else if (s_r.qtr == 2'h2) begin
            s_nxt.sda_oe = 1'b0; // see RULE_17
            s_nxt.phase = ICM_HOLD;
          end
        end
        default: begin
          // Bus free time before the next start
          if (s_r.qtr == 2'h3) begin
            s_nxt.ctrl[`ICM_CTL_STOP] = 1'b0; // see RULE_23
            s_nxt.shift_full = 1'b0;
            s_nxt.phase = ICM_IDLE;
          end
        end
      endcase
    end

    // Write channel
    if (s_axi_awvalid && !s_r.aw_ok) begin
      s_nxt.aw_ok = 1'b1;
      s_nxt.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && !s_r.w_ok) begin
      s_nxt.w_ok = 1'b1;
      s_nxt.w_data = s_axi_wdata;
    end
    if (wr_go) begin
      s_nxt.aw_ok = 1'b0;
      s_nxt.w_ok = 1'b0;
      s_nxt.bvalid = 1'b1;
      s_nxt.bresp = `ICM_RESP_OKAY;
      if (s_r.aw_addr == `ICM_OFF_DATA) begin
        s_nxt.data = s_r.w_data[7:0];
        s_nxt.data_full = 1'b1; // see RULE_14
      end else if (s_r.aw_addr == `ICM_OFF_CTRL) begin
        s_nxt.ctrl = s_r.w_data[4:0];
        if (s_r.w_data[`ICM_CTL_START] || s_r.w_data[`ICM_CTL_STOP]) begin
          // Sequencer only runs with no NAK pending, so a fresh NAK survives
          s_nxt.nak = s_nxt.nak && !s_r.nak; // see RULE_03 see RULE_19
        end
      end else if (s_r.aw_addr == `ICM_OFF_DIV) begin
        s_nxt.div = s_r.w_data[7:0];
      end else if (s_r.aw_addr != `ICM_OFF_STAT) begin
        s_nxt.bresp = `ICM_RESP_SLVERR;
      end
    end
    if (s_r.bvalid && s_axi_bready) begin
      s_nxt.bvalid = 1'b0;
    end

    // Read channel; a data read clears the receive flag
    if (rd_go) begin
      s_nxt.rvalid = 1'b1;
      s_nxt.rdata = rd_val;
      s_nxt.rresp = (s_axi_araddr > `ICM_OFF_DIV || s_axi_araddr[1:0] != 2'b00) ?
                    `ICM_RESP_SLVERR : `ICM_RESP_OKAY;
      if (s_axi_araddr == `ICM_OFF_DATA) begin
        // A byte completing in this same cycle keeps its flag
        s_nxt.rxi = s_nxt.rxi && !s_r.rxi; // see RULE_06
      end
    end
    if (s_r.rvalid && s_axi_rready) begin
      s_nxt.rvalid = 1'b0;
    end
  end

  // State register
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      s_r <= '0;
      s_r.phase <= ICM_IDLE;
      s_r.div <= `ICM_DIV_RESET;
      s_r.sda_sy <= 2'b11;
      s_r.scl_sy <= 2'b11;
    end else begin
      s_r <= s_nxt;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign s_axi_awready = !s_r.aw_ok;
  assign s_axi_wready = !s_r.w_ok;
  assign s_axi_bvalid = s_r.bvalid;
  assign s_axi_bresp = s_r.bresp;
  assign s_axi_arready = !s_r.rvalid;
  assign s_axi_rvalid = s_r.rvalid;
  assign s_axi_rdata = s_r.rdata;
  assign s_axi_rresp = s_r.rresp;
  assign sda_o = 1'b0;
  assign scl_o = 1'b0;
  assign sda_oe = s_r.sda_oe;
  assign scl_oe = s_r.scl_oe;
  // Three separate sources; software polls NAK first
  assign nak_irq = s_r.nak; // see RULE_01 see RULE_05
  assign rx_irq = s_r.rxi;
  assign tx_irq = transmit_irq_enable;

endmodule

/* File: rtl/icm_params.svh */
// Purpose: constants of the I2C master interrupt and bus-condition block
// Assumes: 10 MHz ref_clk, AXI4-Lite with 32-bit data
// Notes: offsets are byte addresses of aligned words
`ifndef ICM_PARAMS_SVH
`define ICM_PARAMS_SVH
// ----------------------------------------
// Register offsets
// ----------------------------------------
`define ICM_OFF_DATA 4'h0
`define ICM_OFF_STAT 4'h4
`define ICM_OFF_CTRL 4'h8
`define ICM_OFF_DIV 4'hc
// ----------------------------------------
// Control bits
// ----------------------------------------
`define ICM_CTL_START 0
`define ICM_CTL_STOP 1
`define ICM_CTL_TXIE 2
`define ICM_CTL_NAK 3
`define ICM_CTL_TENBIT 4
// ----------------------------------------
// Status bits
// ----------------------------------------
`define ICM_ST_NAK 0
`define ICM_ST_TXI 1
`define ICM_ST_RXI 2
`define ICM_ST_TDRE 3
`define ICM_ST_RD 4
`define ICM_ST_BUSY 5
`define ICM_ST_ACK 6
// ----------------------------------------
// Timing and responses
// ----------------------------------------
`define ICM_DIV_RESET 8'h04
`define ICM_RESP_OKAY 2'b00
`define ICM_RESP_SLVERR 2'b10
`define ICM_BIT_LAST 3'h7
`endif

/* File: rtl/icm_pkg.sv */
// Purpose: types of the I2C master interrupt and bus-condition block
// Assumes: nothing beyond the constants header
// Notes: bus phase enum is one-hot
package icm_pkg;
  typedef enum logic [7:0] {
    ICM_IDLE = 8'b0000_0001,
    ICM_START = 8'b0000_0010,
    ICM_SEND = 8'b0000_0100,
    ICM_GETACK = 8'b0000_1000,
    ICM_RECV = 8'b0001_0000,
    ICM_PUTACK = 8'b0010_0000,
    ICM_STOP = 8'b0100_0000,
    ICM_HOLD = 8'b1000_0000
  } icm_phase_e;

  typedef struct packed {
    icm_phase_e phase;
    logic [1:0] qtr;
    logic [7:0] cnt;
    logic [7:0] div;
    logic [2:0] bitn;
    logic [7:0] shift;
    logic shift_full;
    logic [7:0] data;
    logic data_full;
    logic [7:0] rxdata;
    logic [4:0] ctrl;
    logic nak;
    logic rxi;
    logic rd;
    logic ack;
    logic first_addr;
    logic sda_oe;
    logic scl_oe;
    logic [1:0] sda_sy;
    logic [1:0] scl_sy;
    logic aw_ok;
    logic [3:0] aw_addr;
    logic w_ok;
    logic [31:0] w_data;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } icm_state_s;
endpackage

/* File: testbench/icm_master_tb_top.sv */
// Purpose: self-checking bench for the I2C master
// Assumes: AXI4-Lite master tasks, slave model on open-drain wires
// Notes: DIV written to 7 once, then set back to its reset value before the transfers
`timescale 1ns/1ns
`include "icm_params.svh"
module icm_master_tb_top;
  logic ref_clk, rst, awv, wv, brdy, arv, rrdy, awr, wr_rdy, bv, arr, rv_o;
  logic [3:0] awa, ara;
  logic [31:0] wd, rdat, rv;
  logic [1:0] br, rrsp, rr;
  logic sda_oe, scl_oe, tx_irq, rx_irq, nak_irq, sl_pull, scl_hold, nak_addr;
  logic [7:0] got;
  wire sda_w = !(sda_oe || sl_pull);
  wire scl_w = !(scl_oe || scl_hold);
  wire [2:0] flags = {nak_irq, rx_irq, tx_irq};
  int bad_count = 0;
  int n_checks = 0;
  icm_master icm_master_i (.ref_clk(ref_clk), .rst(rst), .s_axi_awaddr(awa),
    .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(4'hf),
    .s_axi_wvalid(wv), .s_axi_wready(wr_rdy), .s_axi_bresp(br), .s_axi_bvalid(bv),
    .s_axi_bready(brdy), .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr),
    .s_axi_rdata(rdat), .s_axi_rresp(rrsp), .s_axi_rvalid(rv_o), .s_axi_rready(rrdy),
    .sda_i(sda_w), .sda_o(), .sda_oe(sda_oe), .scl_i(scl_w), .scl_o(), .scl_oe(scl_oe),
    .tx_irq(tx_irq), .rx_irq(rx_irq), .nak_irq(nak_irq));
  icm_slave_model icm_slave_model_i (.sda(sda_w), .scl(scl_w), .nak_addr(nak_addr),
    .rd_byte(8'h96), .sda_pull(sl_pull), .got(got));
  // Clock
  initial begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      bad_count++;
      $display("BAD %s exp %h got %h", nm, e, g);
    end
  endtask
  // Write: offer aw and w together, drop each when taken, wait response
  task wr(input logic [3:0] a, input logic [31:0] d);
    logic ad, dd;
    ad = 1'b0;
    dd = 1'b0;
    @(posedge ref_clk);
    awa <= a;
    wd <= d;
    awv <= 1'b1;
    wv <= 1'b1;
    brdy <= 1'b1;
    while (!(ad && dd)) begin
      @(posedge ref_clk);
      if (!ad && awr) begin
        ad = 1'b1;
        awv <= 1'b0;
      end
      if (!dd && wr_rdy) begin
        dd = 1'b1;
        wv <= 1'b0;
      end
    end
    while (!bv) @(posedge ref_clk);
    rr = br;
    brdy <= 1'b0;
  endtask
  task rd(input logic [3:0] a);
    @(posedge ref_clk);
    ara <= a;
    arv <= 1'b1;
    rrdy <= 1'b1;
    do @(posedge ref_clk); while (!arr);
    arv <= 1'b0;
    while (!rv_o) @(posedge ref_clk);
    rv = rdat;
    rr = rrsp;
    rrdy <= 1'b0;
  endtask
  task rd_chk(input logic [3:0] a, input logic [31:0] e);
    rd(a);
    chk("read", e, rv);
  endtask
  task wait_flag(input int k, input logic v);
    int n;
    n = 0;
    while (flags[k] !== v && n < 4000) begin
      @(posedge ref_clk);
      n++;
    end
    chk("flag", {31'h0, v}, {31'h0, flags[k]});
  endtask
  task wait_idle;
    int n;
    n = 0;
    rv = 32'h0000_0020;
    while (rv[5] && n < 300) begin
      rd(`ICM_OFF_STAT);
      n++;
    end
    chk("busy", 32'h0, {31'h0, rv[5]});
  endtask
  task test_done;
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  // Watchdog well beyond the few thousand cycles the tests need
  initial begin
    repeat (20000) @(posedge ref_clk);
    bad_count++;
    test_done;
  end
  // Main sequence
  initial begin
    {rst, awv, wv, brdy, arv, rrdy, scl_hold, nak_addr} = 8'h80;
    {awa, ara, wd} = 40'h0;
    repeat (6) @(posedge ref_clk);
    rst <= 1'b0;
    rd_chk(`ICM_OFF_STAT, 32'h0000_0008);
    rd_chk(`ICM_OFF_CTRL, 32'h0000_0000);
    rd_chk(`ICM_OFF_DIV, 32'h0000_0004);
    wr(`ICM_OFF_DIV, 32'h0000_0007);
    rd_chk(`ICM_OFF_DIV, 32'h0000_0007);
    wr(`ICM_OFF_DIV, 32'h0000_0004);
    rd(4'h2);
    chk("rresp", 32'(`ICM_RESP_SLVERR), {30'h0, rr});
    wr(`ICM_OFF_STAT, 32'h0000_00ff);
    chk("bresp", 32'(`ICM_RESP_OKAY), {30'h0, rr});
    wr(4'h2, 32'h0000_0000);
    chk("bresp", 32'(`ICM_RESP_SLVERR), {30'h0, rr});
    rd_chk(`ICM_OFF_STAT, 32'h0000_0008);
    $display("test reset done");
    wr(`ICM_OFF_CTRL, 32'h0000_0004);
    wait_flag(0, 1'b1);
    wr(`ICM_OFF_DATA, 32'h0000_00a4);
    wait_flag(0, 1'b0);
    wr(`ICM_OFF_CTRL, 32'h0000_0005);
    wait_flag(0, 1'b1);
    // Slave stretches the clock once
    wait (scl_oe);
    @(posedge ref_clk);
    scl_hold <= 1'b1;
    repeat (60) @(posedge ref_clk);
    scl_hold <= 1'b0;
    wr(`ICM_OFF_DATA, 32'h0000_003c);
    wait_flag(0, 1'b0);
    wait_flag(0, 1'b1);
    wait_idle;
    chk("stat", 32'h0000_004a, rv);
    chk("got", 32'h0000_003c, {24'h0, got});
    rd_chk(`ICM_OFF_CTRL, 32'h0000_0004);
    $display("test write done");
    wr(`ICM_OFF_CTRL, 32'h0000_0000);
    nak_addr <= 1'b1;
    wr(`ICM_OFF_DATA, 32'h0000_00a4);
    wr(`ICM_OFF_CTRL, 32'h0000_0001);
    wait_flag(2, 1'b1);
    rd(`ICM_OFF_STAT);
    chk("nak bit", 32'h1, {31'h0, rv[0]});
    repeat (100) @(posedge ref_clk);
    wait_flag(2, 1'b1);
    wr(`ICM_OFF_CTRL, 32'h0000_0002);
    wait_flag(2, 1'b0);
    wait_idle;
    chk("stat", 32'h0000_0008, rv);
    nak_addr <= 1'b0;
    $display("test refused address done");
    wr(`ICM_OFF_DATA, 32'h0000_00a5);
    wr(`ICM_OFF_CTRL, 32'h0000_0009);
    wait_flag(1, 1'b1);
    wr(`ICM_OFF_CTRL, 32'h0000_000a);
    rd_chk(`ICM_OFF_DATA, 32'h0000_0096);
    wait_flag(1, 1'b0);
    wait_flag(2, 1'b1);
    wr(`ICM_OFF_CTRL, 32'h0000_0002);
    wait_flag(2, 1'b0);
    wait_idle;
    chk("stat", 32'h0000_0058, rv);
    $display("test read done");
    // Start with nothing to send, then a read-direction ten-bit address
    wr(`ICM_OFF_CTRL, 32'h0000_0015);
    wait_flag(0, 1'b1);
    wr(`ICM_OFF_DATA, 32'h0000_00f1);
    wait_flag(0, 1'b0);
    wait_flag(0, 1'b1);
    wait_idle;
    chk("stat", 32'h0000_005a, rv);
    rd_chk(`ICM_OFF_CTRL, 32'h0000_0014);
    $display("test ten-bit done");
    test_done;
  end
endmodule
bind icm_master icm_properties icm_properties_i (.*);

/* File: testbench/icm_properties.sv */
// Purpose: port assertions for the I2C master
// Assumes: DIV at reset value, aw and w taken together
// Notes: bound from the bench top
`timescale 1ns/1ns
`include "icm_params.svh"
module icm_properties (
  // Clock and reset
  input logic ref_clk,
  input logic rst,
  // Register bus
  input logic [3:0] s_axi_awaddr,
  input logic s_axi_awvalid,
  input logic s_axi_awready,
  input logic [31:0] s_axi_wdata,
  input logic [3:0] s_axi_araddr,
  input logic s_axi_arvalid,
  input logic s_axi_arready,
  // Pins and flags
  input logic scl_i,
  input logic sda_oe,
  input logic scl_oe,
  input logic tx_irq,
  input logic rx_irq,
  input logic nak_irq
);
  // ----
  // Helpers
  // ----
  logic ctl_wr;
  logic txen_r;
  logic [2:0] ss_r;
  assign ctl_wr = s_axi_awvalid && s_axi_awready && s_axi_awaddr == `ICM_OFF_CTRL;
  // Shadow enable bit; start/stop writes kept three cycles for register latency
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      txen_r <= 1'b0;
      ss_r <= 3'h0;
    end else begin
      if (ctl_wr) txen_r <= s_axi_wdata[`ICM_CTL_TXIE];
      ss_r <= {ss_r[1:0], ctl_wr && s_axi_wdata[1:0] != 2'h0};
    end
  end
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  sequence s_start;
    $rose(sda_oe) && !scl_oe;
  endsequence
  sequence s_stop;
    $fell(sda_oe) && !scl_oe;
  endsequence
  sequence s_held;
    (nak_irq || rx_irq) ##1 (nak_irq || rx_irq);
  endsequence
  sequence s_stretch;
    (!scl_oe && !scl_i) [*4];
  endsequence
  a_flag_freeze: assert property (
    s_held |-> $stable(sda_oe) && $stable(scl_oe))
    else $error("bus moved while a flag was pending");
  a_start_shape: assert property (s_start |-> ##[1:40] (scl_oe && sda_oe))
    else $error("start not followed by clock low");
  a_stop_shape: assert property (
    s_stop |-> $past(scl_oe, 4) == 1'b0 && $past(scl_oe, 2) == 1'b0)
    else $error("stop not in middle of clock high");
  a_data_edge: assert property ($changed(sda_oe) |-> !$fell(scl_oe))
    else $error("data changed as clock rose");
  a_stretch_hold: assert property (s_stretch |-> $stable(sda_oe) && !scl_oe)
    else $error("bus moved while clock held low");
  a_rx_clear: assert property (s_axi_arvalid && s_axi_arready && rx_irq
    && s_axi_araddr == `ICM_OFF_DATA |-> ##[1:2] !rx_irq)
    else $error("receive flag not cleared by read");
  a_tx_clear: assert property (s_axi_awvalid && s_axi_awready
    && s_axi_awaddr == `ICM_OFF_DATA |-> ##[1:3] !tx_irq)
    else $error("transmit flag not cleared by write");
  a_tx_enable: assert property (
    tx_irq |-> txen_r || $past(txen_r) || $past(txen_r, 2))
    else $error("transmit flag while disabled");
  a_nak_clear: assert property ($fell(nak_irq) |-> ss_r != 3'h0)
    else $error("nak flag cleared without start or stop");
endmodule

/* File: testbench/icm_slave_model.sv */
// Purpose: behavioural I2C slave for the bench
// Assumes: wires pulled up, one byte pattern for reads
// Notes: repeated start not modelled
`timescale 1ns/1ns
module icm_slave_model (
  // Bus wires
  input logic sda,
  input logic scl,
  // Test controls
  input logic nak_addr,
  input logic [7:0] rd_byte,
  // Slave drive and capture
  output logic sda_pull,
  output logic [7:0] got
);
  logic [7:0] b;
  logic rd;
  logic first;
  int i;
  // Byte engine, restarted at each start, dropped at stop
  initial begin
    sda_pull = 1'b0;
    got = 8'h00;
    forever begin
      @(negedge sda iff scl);
      first = 1'b1;
      rd = 1'b0;
      fork
        forever begin
          if (!rd || first) begin
            for (i = 7; i >= 0; i--) begin
              @(posedge scl);
              b[i] = sda;
            end
            @(negedge scl);
            sda_pull = !(first && nak_addr);
            if (first) rd = b[0];
            else got = b;
            first = 1'b0;
            @(negedge scl);
            sda_pull = 1'b0;
          end else begin
            // Read data changes only while clock is low
            for (i = 7; i >= 0; i--) begin
              sda_pull = !rd_byte[i];
              @(negedge scl);
            end
            sda_pull = 1'b0;
            @(posedge scl);
            if (sda) forever @(posedge scl);
            @(negedge scl);
          end
        end
        @(posedge sda iff scl);
      join_any
      disable fork;
      sda_pull = 1'b0;
    end
  end
endmodule
